// file: common/mcu_decoder_regs.svh
`ifndef MCU_DECODER_REGS_SVH
`define MCU_DECODER_REGS_SVH
// Bus byte offsets
`define OFS_INSTR 8'h00
`define OFS_ACC 8'h04
`define OFS_STATUS 8'h08
`define OFS_PC 8'h0c
`define OFS_FADDR 8'h10
`define OFS_FDATA 8'h14
`define OFS_CFG 8'h18
// Status and config bit positions
`define ST_CARRY 0
`define ST_DCARRY 1
`define ST_ZERO 2
`define ST_POWERDOWN 3
`define ST_TIMEOUT 4
`define ST_BUSY 5
`define CFG_PRESCALE 0
// File locations with side effects
`define FILE_TIMER_ZERO 7'h01
`define FILE_IO_PORT 7'h06
// Byte-oriented opcodes
`define OPC_MISC 4'h0
`define OPC_CLR 4'h1
`define OPC_SUB 4'h2
`define OPC_DEC 4'h3
`define OPC_OR 4'h4
`define OPC_AND 4'h5
`define OPC_XOR 4'h6
`define OPC_ADD 4'h7
`define OPC_MOVE 4'h8
`define OPC_COM 4'h9
`define OPC_INC 4'ha
`define OPC_DECSKIP 4'hb
`define OPC_RR 4'hc
`define OPC_RL 4'hd
`define OPC_SWAP 4'he
`define OPC_INCSKIP 4'hf
// Control words
`define CW_RETURN 8'h08
`define CW_RETURN_IRQ 8'h09
`define CW_STANDBY 8'h63
`define CW_WDT_CLEAR 8'h64
// Timing: one instruction cycle is four clocks
`define PHASE_LAST 2'd3
`define STACK_DEPTH 8
`endif

// file: common/mcu_decoder_pkg.sv
package mcu_decoder_pkg;
    typedef enum logic [1:0] {IDLE, EXEC, NOPCYC} exec_state_e;
    typedef logic [13:0] instr_t;
    typedef logic [7:0] byte_t;
    typedef logic [10:0] pc_t;
endpackage

// file: hdl/mcu_instruction_decoder.sv
// Implementation choices: the AHB-Lite register port and the register offsets.
`include "mcu_decoder_regs.svh"

// Functional notes
// - Every file-naming instruction reads its register first; those with a file result then modify and write it back.
// - Destination bit 0 sends result to accumulator, 1 back to file.
// - File address field is seven bits, registers 0x00 to 0x7F.
// - Three-bit bit-select picks one bit of an 8-bit register.
// - Don't-care positions decode the same whether 0 or 1.
// - Add/subtract set carry, digit carry, zero; AND/OR/XOR set zero only.
// - Complement, move, clear set zero; swap no flags; store accumulator.
// - Increment/decrement set zero; skip variants skip on zero, no flags.
// - Rotates go through carry and change only carry.
// - Bit clear, set, test-skip-clear, test-skip-set; no flags changed.
// - Taken skip costs two cycles, second one a no-operation.
// - Literal OR, AND, XOR set zero; move literal changes no flags.
// - Literal add and literal-minus-accumulator set carry, digit carry, zero.
// - Call and jump take 11-bit target; PC changes cost two cycles.
// - Return with literal loads accumulator; returns take two cycles.
// - Watchdog clear and standby are single cycle, update status bits.
// - I/O port read-modify-write reads pin levels, not latch.
// - Writing timer-zero count clears prescaler when assigned to it.
// - One instruction cycle is four clocks.
// - Standby clears watchdog, sets time-out bit, clears power-down bit.
module mcu_instruction_decoder (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Port pins and side effects
    input wire mcu_decoder_pkg::byte_t portPins,
    output mcu_decoder_pkg::byte_t portLatch,
    output logic prescalerClear,
    output logic watchdogClear
);
    import mcu_decoder_pkg::*;

    exec_state_e state;
    logic [1:0] phase;
    instr_t instr;
    byte_t acc;
    byte_t opnd;
    pc_t pc;
    logic carry, dcarry, zero, powerdownStatusBit, timeoutStatusBit, presAssign;
    logic [6:0] fileAddr;
    byte_t fileMem [0:127];
    pc_t stack [0:`STACK_DEPTH-1];
    logic [2:0] sp;
    byte_t pinMeta, pinSync;
    logic dValid, dWrite;
    logic [7:0] dAddr;
    logic wrEn, startExec, execLast, busy;
    logic [31:0] rdMux;
    byte_t readVal, res, bmask, lit;
    logic toFile, toAcc, dSel, setZ, setC, setDigit, arith, nc, ndc;
    logic skip, jump, push, pop, wdt, sleep, twoCyc;
    pc_t target;
    logic [8:0] sum;
    logic [4:0] half;

    // Bus slave: writes wait while an instruction runs
    assign busy = (state != IDLE);
    assign hreadyout = ~(dValid & dWrite & busy);
    assign hresp = 1'b0;
    assign wrEn = dValid & dWrite & hreadyout;
    assign startExec = wrEn & (dAddr == `OFS_INSTR);
    assign execLast = (state == EXEC) && (phase == `PHASE_LAST);
    assign portLatch = fileMem[`FILE_IO_PORT];

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            dValid <= 1'b0;
            dWrite <= 1'b0;
            dAddr <= 8'h00;
        end else if (hready) begin
            dValid <= hsel & htrans[1];
            dWrite <= hwrite;
            dAddr <= haddr[7:0];
        end
    end

    always_comb begin
        rdMux = 32'h0000_0000;
        if (haddr[7:0] == `OFS_INSTR) begin
            rdMux[13:0] = instr;
        end else if (haddr[7:0] == `OFS_ACC) begin
            rdMux[7:0] = acc;
        end else if (haddr[7:0] == `OFS_STATUS) begin
            rdMux[`ST_CARRY] = carry;
            rdMux[`ST_DCARRY] = dcarry;
            rdMux[`ST_ZERO] = zero;
            rdMux[`ST_POWERDOWN] = powerdownStatusBit;
            rdMux[`ST_TIMEOUT] = timeoutStatusBit;
            rdMux[`ST_BUSY] = busy;
        end else if (haddr[7:0] == `OFS_PC) begin
            rdMux[10:0] = pc;
        end else if (haddr[7:0] == `OFS_FADDR) begin
            rdMux[6:0] = fileAddr;
        end else if (haddr[7:0] == `OFS_FDATA) begin
            rdMux[7:0] = fileMem[fileAddr];
        end else if (haddr[7:0] == `OFS_CFG) begin
            rdMux[`CFG_PRESCALE] = presAssign;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= rdMux;
        end
    end

    // Pin synchroniser
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pinMeta <= 8'h00;
            pinSync <= 8'h00;
        end else begin
            pinMeta <= portPins;
            pinSync <= pinMeta;
        end
    end

    // Operand source: port reads pin levels
    assign readVal = (instr[6:0] == `FILE_IO_PORT) ? pinSync : fileMem[instr[6:0]];
    assign bmask = 8'h01 << instr[9:7];
    assign lit = instr[7:0];

    always_comb begin
        res = opnd;
        {toFile, toAcc, dSel, setZ, setC, setDigit, arith, nc, ndc} = 9'h000;
        {skip, jump, push, pop, wdt, sleep} = 6'h00;
        target = pc + 11'd1;
        sum = 9'h000;
        half = 5'h00;
        case (instr[13:12])
            2'b00: begin
                dSel = 1'b1;
                case (instr[11:8])
                    `OPC_ADD: begin
                        sum = {1'b0, opnd} + {1'b0, acc};
                        half = {1'b0, opnd[3:0]} + {1'b0, acc[3:0]};
                        arith = 1'b1;
                    end
                    `OPC_SUB: begin
                        sum = {1'b0, opnd} + {1'b0, ~acc} + 9'h001;
                        half = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
                        arith = 1'b1;
                    end
                    `OPC_AND: begin res = opnd & acc; setZ = 1'b1; end
                    `OPC_OR: begin res = opnd | acc; setZ = 1'b1; end
                    `OPC_XOR: begin res = opnd ^ acc; setZ = 1'b1; end
                    `OPC_COM: begin res = ~opnd; setZ = 1'b1; end
                    `OPC_MOVE: setZ = 1'b1;
                    `OPC_SWAP: res = {opnd[3:0], opnd[7:4]};
                    `OPC_INC: begin res = opnd + 8'h01; setZ = 1'b1; end
                    `OPC_DEC: begin res = opnd - 8'h01; setZ = 1'b1; end
                    `OPC_INCSKIP: begin
                        res = opnd + 8'h01;
                        skip = (res == 8'h00);
                    end
                    `OPC_DECSKIP: begin
                        res = opnd - 8'h01;
                        skip = (res == 8'h00);
                    end
                    `OPC_RL: begin
                        res = {opnd[6:0], carry};
                        setC = 1'b1;
                        nc = opnd[7];
                    end
                    `OPC_RR: begin
                        res = {carry, opnd[7:1]};
                        setC = 1'b1;
                        nc = opnd[0];
                    end
                    `OPC_CLR: begin res = 8'h00; setZ = 1'b1; end
                    default: begin
                        dSel = 1'b0;
                        if (instr[7]) begin
                            res = acc;
                            toFile = 1'b1;
                        end else if (instr[7:0] == `CW_RETURN
                                || instr[7:0] == `CW_RETURN_IRQ) begin
                            pop = 1'b1;
                        end else if (instr[7:0] == `CW_WDT_CLEAR) begin
                            wdt = 1'b1;
                        end else if (instr[7:0] == `CW_STANDBY) begin
                            sleep = 1'b1;
                        end
                    end
                endcase
            end
            2'b01: begin
                case (instr[11:10])
                    2'b00: begin res = opnd & ~bmask; toFile = 1'b1; end
                    2'b01: begin res = opnd | bmask; toFile = 1'b1; end
                    2'b10: skip = ((opnd & bmask) == 8'h00);
                    default: skip = ((opnd & bmask) != 8'h00);
                endcase
            end
            2'b10: begin
                target = instr[10:0];
                jump = 1'b1;
                push = ~instr[11];
            end
            default: begin
                casez (instr[11:8])
                    4'b00??: begin res = lit; toAcc = 1'b1; end
                    4'b01??: begin res = lit; toAcc = 1'b1; pop = 1'b1; end
                    4'b1000: begin res = lit | acc; toAcc = 1'b1; setZ = 1'b1; end
                    4'b1001: begin res = lit & acc; toAcc = 1'b1; setZ = 1'b1; end
                    4'b1010: begin res = lit ^ acc; toAcc = 1'b1; setZ = 1'b1; end
                    4'b110?: begin
                        sum = {1'b0, lit} + {1'b0, ~acc} + 9'h001;
                        half = {1'b0, lit[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
                        arith = 1'b1;
                        toAcc = 1'b1;
                    end
                    4'b111?: begin
                        sum = {1'b0, lit} + {1'b0, acc};
                        half = {1'b0, lit[3:0]} + {1'b0, acc[3:0]};
                        arith = 1'b1;
                        toAcc = 1'b1;
                    end
                    default: res = opnd;
                endcase
            end
        endcase
        if (arith) begin
            res = sum[7:0];
            {setC, setDigit, setZ} = 3'b111;
            nc = sum[8];
            ndc = half[4];
        end
        if (dSel) begin
            toFile = instr[7];
            toAcc = ~instr[7];
        end
        if (pop) begin
            target = stack[sp - 3'd1];
        end else if (skip) begin
            target = pc + 11'd2;
        end
    end

    assign twoCyc = skip | jump | pop;

    // Sequencer: four clocks per instruction cycle
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state <= IDLE;
            phase <= 2'd0;
        end else begin
            case (state)
                IDLE: begin
                    phase <= 2'd0;
                    if (startExec) begin
                        state <= EXEC;
                    end
                end
                EXEC: begin
                    phase <= phase + 2'd1;
                    if (phase == `PHASE_LAST) begin
                        state <= twoCyc ? NOPCYC : IDLE;
                    end
                end
                default: begin
                    phase <= phase + 2'd1;
                    if (phase == `PHASE_LAST) begin
                        state <= IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            instr <= 14'h0000;
            opnd <= 8'h00;
        end else begin
            if (startExec) begin
                instr <= hwdata[13:0];
            end
            if (state == EXEC && phase == 2'd0) begin
                opnd <= readVal;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            acc <= 8'h00;
        end else if (execLast && toAcc) begin
            acc <= res;
        end else if (wrEn && dAddr == `OFS_ACC) begin
            acc <= hwdata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            {carry, dcarry, zero} <= 3'b000;
            timeoutStatusBit <= 1'b1;
            powerdownStatusBit <= 1'b1;
        end else if (execLast) begin
            if (setC) carry <= nc;
            if (setDigit) dcarry <= ndc;
            if (setZ) zero <= (res == 8'h00);
            if (sleep) begin
                timeoutStatusBit <= 1'b1;
                powerdownStatusBit <= 1'b0;
            end else if (wdt) begin
                timeoutStatusBit <= 1'b1;
                powerdownStatusBit <= 1'b1;
            end
        end else if (wrEn && dAddr == `OFS_STATUS) begin
            carry <= hwdata[`ST_CARRY];
            dcarry <= hwdata[`ST_DCARRY];
            zero <= hwdata[`ST_ZERO];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            for (int i = 0; i < 128; i++) begin
                fileMem[i] <= 8'h00;
            end
        end else if (execLast && toFile) begin
            fileMem[instr[6:0]] <= res;
        end else if (wrEn && dAddr == `OFS_FDATA) begin
            fileMem[fileAddr] <= hwdata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            fileAddr <= 7'h00;
            presAssign <= 1'b0;
        end else if (wrEn && dAddr == `OFS_FADDR) begin
            fileAddr <= hwdata[6:0];
        end else if (wrEn && dAddr == `OFS_CFG) begin
            presAssign <= hwdata[`CFG_PRESCALE];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pc <= 11'h000;
            sp <= 3'd0;
        end else if (execLast) begin
            pc <= target;
            if (push) begin
                stack[sp] <= pc + 11'd1;
                sp <= sp + 3'd1;
            end else if (pop) begin
                sp <= sp - 3'd1;
            end
        end else if (wrEn && dAddr == `OFS_PC) begin
            pc <= hwdata[10:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            prescalerClear <= 1'b0;
            watchdogClear <= 1'b0;
        end else begin
            prescalerClear <= execLast & toFile & presAssign
                & (instr[6:0] == `FILE_TIMER_ZERO);
            watchdogClear <= execLast & (wdt | sleep);
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    rmw_read_a: assert property (execLast && toFile |-> $past(state, 3) == EXEC)
        else $error("file write without read phase");
    dest_acc_a: assert property (execLast && dSel && !instr[7]
        && instr[13:12] == 2'b00 |=> acc == $past(res))
        else $error("accumulator destination not taken");
    clear_zero_a: assert property (execLast && instr[13:8] == 6'h01 |=> zero)
        else $error("clear left zero flag low");
    bit_flags_a: assert property (execLast && instr[13:12] == 2'b01
        |=> $stable({carry, dcarry, zero}))
        else $error("bit operation changed flags");
    skip_two_a: assert property (execLast && skip
        |=> state == NOPCYC [*4] ##1 state == IDLE)
        else $error("taken skip not two cycles");
    single_cycle_a: assert property ($rose(busy) && !twoCyc ##3 !twoCyc |=> !busy)
        else $error("single-cycle instruction overran");
    port_pins_a: assert property (state == EXEC && phase == 2'd0
        && instr[6:0] == `FILE_IO_PORT |=> opnd == $past(pinSync))
        else $error("port operand not from pins");
    prescale_clr_a: assert property (execLast && toFile && presAssign
        && instr[6:0] == `FILE_TIMER_ZERO |=> prescalerClear)
        else $error("prescaler not cleared");
    standby_status_a: assert property (execLast && sleep
        |=> timeoutStatusBit && !powerdownStatusBit && watchdogClear)
        else $error("standby status wrong");
    jump_target_a: assert property (execLast && jump |=> pc == $past(instr[10:0]))
        else $error("jump target not loaded");
endmodule // mcu_instruction_decoder

// file: tb/prog_memory.sv
module prog_memory (
    // Fetch port
    input wire mcu_decoder_pkg::pc_t fetchAddr,
    output mcu_decoder_pkg::instr_t fetchWord
);
    timeunit 1ns;
    timeprecision 1ns;
    import mcu_decoder_pkg::*;

    instr_t rom [0:2047];

    // Words never loaded read as a no-operation
    initial begin
        foreach (rom[a]) begin
            rom[a] = 14'h0000;
        end
        // Call, jump and return chain walked by the bench
        rom[0] = 14'h2010;
        rom[16] = 14'h345a;
        rom[1] = 14'h2820;
        rom[32] = 14'h2030;
        rom[48] = 14'h0009;
        rom[33] = 14'h2040;
        rom[64] = 14'h0008;
    end

    assign fetchWord = rom[fetchAddr];
endmodule // prog_memory

// file: tb/mcu_instruction_decoder_test.sv
`include "mcu_decoder_regs.svh"
`define CHK(a, b) begin \
    testsRun++; \
    if ((a) !== (b)) begin \
        nFail++; \
        $display("BAD t=%0t got %h exp %h", $time, (a), (b)); \
    end \
end

module mcu_instruction_decoder_test;
    timeunit 1ns;
    timeprecision 1ns;
    import mcu_decoder_pkg::*;

    typedef struct packed {byte_t w; byte_t f; logic c; logic hc; logic z; logic sk;} res_s;

    logic core_clk;
    logic resetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    byte_t portPins;
    byte_t portLatch;
    logic prescalerClear;
    logic watchdogClear;
    pc_t fetchAddr;
    instr_t fetchWord;
    logic [15:0] seed;
    int nFail = 0;
    int testsRun = 0;
    int nPre = 0;
    int nWd = 0;

    mcu_instruction_decoder i_dut (
        .core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .portPins(portPins), .portLatch(portLatch), .prescalerClear(prescalerClear),
        .watchdogClear(watchdogClear)
    );

    prog_memory i_mem (.fetchAddr(fetchAddr), .fetchWord(fetchWord));

    initial begin
        core_clk = 1'b0;
        forever begin
            #5 core_clk = ~core_clk;
        end
    end

    always @(posedge core_clk) begin
        if (prescalerClear === 1'b1) begin
            nPre <= nPre + 1;
        end
        if (watchdogClear === 1'b1) begin
            nWd <= nWd + 1;
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        logic [15:0] v;
        v = s;
        for (int k = 0; k < 16; k++) begin
            v = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
        end
        return v;
    endfunction

    // Expected working register, file value, flags and skip of one instruction
    function automatic res_s model(input instr_t i, input byte_t w, input byte_t f,
            input logic [2:0] fl);
        res_s r;
        logic [8:0] s;
        byte_t v;
        byte_t k;
        r = '{w, f, fl[0], fl[1], fl[2], 1'b0};
        v = f;
        k = i[7:0];
        if (i[13:12] == 2'b00) begin
            case (i[11:8])
                4'h7: begin s = f + w; v = s[7:0]; r.c = s[8]; r.hc = (f[3:0] + w[3:0]) > 15; end
                4'h2: begin v = f - w; r.c = f >= w; r.hc = f[3:0] >= w[3:0]; end
                4'h5: v = f & w;
                4'h4: v = f | w;
                4'h6: v = f ^ w;
                4'h9: v = ~f;
                4'he: v = {f[3:0], f[7:4]};
                4'h0: v = w;
                4'h1: v = 8'h00;
                4'ha, 4'hf: v = f + 8'h01;
                4'h3, 4'hb: v = f - 8'h01;
                4'hd: begin v = {f[6:0], fl[0]}; r.c = f[7]; end
                4'hc: begin v = {fl[0], f[7:1]}; r.c = f[0]; end
                default: v = f;
            endcase
            if (!(i[11:8] inside {4'h0, 4'he, 4'hb, 4'hf, 4'hd, 4'hc})) begin
                r.z = (v == 8'h00);
            end
            r.sk = (i[11:8] inside {4'hb, 4'hf}) && (v == 8'h00);
            if (i[7]) begin
                r.f = v;
            end else begin
                r.w = v;
            end
        end else if (i[13:12] == 2'b01) begin
            case (i[11:10])
                2'b00: r.f[i[9:7]] = 1'b0;
                2'b01: r.f[i[9:7]] = 1'b1;
                2'b10: r.sk = !f[i[9:7]];
                default: r.sk = f[i[9:7]];
            endcase
        end else begin
            casez (i[11:8])
                4'b00??: r.w = k;
                4'b1000: r.w = w | k;
                4'b1001: r.w = w & k;
                4'b1010: r.w = w ^ k;
                4'b110?: begin r.w = k - w; r.c = k >= w; r.hc = k[3:0] >= w[3:0]; end
                4'b111?: begin
                    s = k + w;
                    r.w = s[7:0];
                    r.c = s[8];
                    r.hc = (k[3:0] + w[3:0]) > 15;
                end
                default: r.w = w;
            endcase
            if (i[11] && i[11:8] != 4'hb) begin
                r.z = (r.w == 8'h00);
            end
        end
        return r;
    endfunction

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Counts cycles with hready low, ends just after the accepting edge
    task automatic waitReady(output int n);
        n = 0;
        @(negedge core_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 40) begin
                nFail++;
                summarize();
            end
            @(negedge core_clk);
        end
        @(posedge core_clk);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] rd, output int st);
        int n;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        waitReady(n);
        htrans <= 2'b00;
        hwdata <= d;
        waitReady(st);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        int s;
        bus(1'b1, a, d, x, s);
    endtask

    task automatic rdr(input logic [7:0] a, output logic [31:0] d);
        int s;
        bus(1'b0, a, 32'h0, d, s);
    endtask

    task automatic exec(input instr_t i);
        logic [31:0] s;
        int k;
        wr(`OFS_INSTR, {18'h0, i});
        k = 0;
        s = 32'h20;
        while (s[5] !== 1'b0) begin
            rdr(`OFS_STATUS, s);
            k++;
            if (k > 20) begin
                nFail++;
                summarize();
            end
        end
    endtask

    // Stall seen by a write that follows the instruction at once
    task automatic timed(input instr_t i, output int n);
        logic [31:0] x;
        wr(`OFS_INSTR, {18'h0, i});
        bus(1'b1, 8'h40, 32'h0, x, n);
    endtask

    task automatic setup(input byte_t w, input logic [6:0] fa, input byte_t f,
            input logic [2:0] fl);
        wr(`OFS_ACC, {24'h0, w});
        wr(`OFS_FADDR, {25'h0, fa});
        wr(`OFS_FDATA, {24'h0, f});
        wr(`OFS_STATUS, {29'h0, fl});
        wr(`OFS_PC, 32'h100);
    endtask

    initial begin
        logic [31:0] rd;
        instr_t i;
        res_s e;
        int n0;
        int nt [6];
        instr_t tw [6];
        pc_t pcExp [7];
        resetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        portPins = 8'h0f;
        fetchAddr = 11'h000;
        seed = 16'ha1b0;
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        rdr(`OFS_STATUS, rd);
        `CHK(rd[5:0], 6'h18)
        wr(8'h40, 32'hffffffff);
        rdr(8'h40, rd);
        `CHK(rd, 32'h0)
        `CHK(hresp, 1'b0)
        repeat (80) begin
            seed = lfsr(seed);
            i = seed[13:0];
            if (i[13:12] == 2'b10) i[12] = 1'b1;
            if (i[13:12] == 2'b11 && i[11:10] == 2'b01) i[11] = 1'b1;
            if (i[13:12] == 2'b00 && i[11:8] == 4'h0) i[7] = 1'b1;
            if (i[6:0] < 7'h08) i[5] = 1'b1;
            seed = lfsr(seed);
            setup(seed[7:0], i[6:0], seed[15:8], seed[10:8]);
            e = model(i, seed[7:0], seed[15:8], seed[10:8]);
            exec(i);
            rdr(`OFS_ACC, rd);
            `CHK(rd[7:0], e.w)
            rdr(`OFS_FDATA, rd);
            `CHK(rd[7:0], e.f)
            rdr(`OFS_STATUS, rd);
            `CHK(rd[5:0], {3'b011, e.z, e.hc, e.c})
            rdr(`OFS_PC, rd);
            `CHK(rd[10:0], 11'h101 + e.sk)
        end
        setup(8'h01, 7'h7f, 8'h80, 3'h0);
        exec(14'h07ff);
        rdr(`OFS_FDATA, rd);
        `CHK(rd[7:0], 8'h81)
        setup(8'h00, 7'h06, 8'hff, 3'h0);
        exec(14'h0886);
        rdr(`OFS_FDATA, rd);
        `CHK(rd[7:0], 8'h0f)
        `CHK(portLatch, 8'h0f)
        wr(`OFS_CFG, 32'h1);
        n0 = nPre;
        exec(14'h0181);
        `CHK(nPre - n0, 1)
        exec(14'h0801);
        wr(`OFS_CFG, 32'h0);
        exec(14'h0181);
        `CHK(nPre - n0, 1)
        n0 = nWd;
        exec(14'h0063);
        rdr(`OFS_STATUS, rd);
        `CHK(rd[4:3], 2'b10)
        `CHK(nWd - n0, 1)
        exec(14'h0064);
        rdr(`OFS_STATUS, rd);
        `CHK(rd[4:3], 2'b11)
        `CHK(nWd - n0, 2)
        setup(8'h00, 7'h30, 8'hff, 3'h0);
        tw = '{14'h0000, 14'h0060, 14'h3b55, 14'h19b0, 14'h1db0, 14'h2805};
        foreach (tw[k]) begin
            timed(tw[k], nt[k]);
        end
        `CHK(nt[1], nt[0])
        `CHK(nt[2], nt[0])
        `CHK(nt[3], nt[0])
        `CHK(nt[4], nt[0] + 4)
        `CHK(nt[5], nt[0] + 4)
        pcExp = '{11'h010, 11'h001, 11'h020, 11'h030, 11'h021, 11'h040, 11'h022};
        wr(`OFS_PC, 32'h0);
        foreach (pcExp[k]) begin
            rdr(`OFS_PC, rd);
            fetchAddr <= rd[10:0];
            @(posedge core_clk);
            exec(fetchWord);
            rdr(`OFS_PC, rd);
            `CHK(rd[10:0], pcExp[k])
        end
        rdr(`OFS_ACC, rd);
        `CHK(rd[7:0], 8'h5a)
        summarize();
    end
endmodule // mcu_instruction_decoder_test
